// File: inc/sarcs_defs.svh
// Constants of the successive-approximation conversion sequencer
// Behaviour
// - Accepted start sets busy and releases the gated conversion clock.
// - A full conversion runs the gated clock for exactly 17 cycles.
// - Start's trailing edge initialises all parallel result bits, busy and inhibit.
// - First step trials the top bit; later steps decide, all but the last trial next.
// - After the last decision busy clears; parallel word is then valid.
// - Busy low reapplies inhibit; clock output stays low until next start.
// - Each parallel bit changes on the clock edge of its decision.
// - Parallel and serial results are negative true.
// - Codes are complemented straight or offset binary, by input range.
// - Parallel data settles at least 20 ns before busy falls.
// - Serial result leaves msb first, lsb last, non-return-to-zero.
// - Result outputs change on rising clock edges, apart from start's initialisation; valid 120 ns later.
// - All serial bits sit in place at end of conversion.
// - Short-cycle tap at bit N+1 ends conversion after bit N.
// - Resolutions 8, 10, 12 to 15 supported; open tap gives 16 bits.
// - Conversion starts on start's falling edge; busy high throughout.
`ifndef SARCS_DEFS_SVH
`define SARCS_DEFS_SVH
`define SARCS_BITS 16
`define SARCS_INIT_WORD 16'hffff
`define SARCS_T0_WORD 16'h7fff
`define SARCS_SYS_CLK_NS 25
`define SARCS_LINK_CLK_NS 160
`define SARCS_SETUP_NS 20
`define SARCS_SER_VALID_NS 120
`define SARCS_RST_HOLD_CYC 32
`define SARCS_SETUP_CYC \
  ((`SARCS_SETUP_NS + `SARCS_LINK_CLK_NS - 1) / `SARCS_LINK_CLK_NS)
`define SARCS_SER_VALID_CYC \
  ((`SARCS_SER_VALID_NS + `SARCS_LINK_CLK_NS - 1) / `SARCS_LINK_CLK_NS)
`endif

// File: inc/sarcs_pkg.sv
// Types of the successive-approximation conversion sequencer
package sarcs_pkg;
  typedef enum logic [1:0] {
    SARCS_IDLE,
    SARCS_RUN,
    SARCS_STOP
  } sarcs_state_t;
endpackage

// File: rtl/sarcs_top.sv
// Successive-approximation conversion sequencer with gated clock
`timescale 1ns/1ps
`default_nettype none
`include "sarcs_defs.svh"
module sarcs_top #(
  parameter int DATA_W = `SARCS_BITS,
  parameter int STEP_W = $clog2(`SARCS_BITS) + 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic convert_start_in,
  input wire logic comparator_in,
  input wire logic [STEP_W-1:0] short_cycle_tap_in,
  output logic busy_out,
  output logic conv_clk_out,
  output logic [DATA_W-1:0] parallel_data_n_out,
  output logic serial_data_n_out
);
  localparam int IDX_W = $clog2(DATA_W);
  localparam logic [STEP_W-1:0] FULL = STEP_W'(DATA_W);
  localparam logic [STEP_W-1:0] ONE = STEP_W'(1);
  localparam logic [STEP_W-1:0] TWO = STEP_W'(2);
  localparam int RST_W = $clog2(`SARCS_RST_HOLD_CYC) + 1;
  localparam logic [RST_W-1:0] RST_HOLD = RST_W'(`SARCS_RST_HOLD_CYC);

  // Start pin, system clock side
  logic start_s1_reg, start_s2_reg, start_s3_reg, req_tgl_reg;
  logic req_tgl_next;

  always_comb begin
    req_tgl_next = req_tgl_reg;
    if (start_s3_reg && !start_s2_reg) begin
      req_tgl_next = ~req_tgl_reg;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
      start_s3_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
    end else begin
      start_s1_reg <= convert_start_in;
      start_s2_reg <= start_s1_reg;
      start_s3_reg <= start_s2_reg;
      req_tgl_reg <= req_tgl_next;
    end
  end

  // Link side reset stretched: a pin reset of a few system cycles
  // would otherwise end before the slow link clock samples it
  logic [RST_W-1:0] rst_hold_reg, rst_hold_next;
  logic rst_done_reg, rst_done_next;

  always_comb begin
    rst_hold_next = rst_hold_reg;
    rst_done_next = 1'b0;
    if (rst_hold_reg == RST_HOLD) begin
      rst_done_next = 1'b1;
    end else begin
      rst_hold_next = RST_W'(rst_hold_reg + 1'b1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rst_hold_reg <= '0;
      rst_done_reg <= 1'b0;
    end else begin
      rst_hold_reg <= rst_hold_next;
      rst_done_reg <= rst_done_next;
    end
  end

  // Link side synchronisers, reset included
  logic lrst_s1_reg, lrst_n_reg;
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic comp_s1_reg, comp_s2_reg;
  logic [STEP_W-1:0] tap_s1_reg, tap_s2_reg;

  always_ff @(posedge link_clk_in) begin
    lrst_s1_reg <= rst_done_reg;
    lrst_n_reg <= lrst_s1_reg;
    tgl_s1_reg <= req_tgl_reg;
    tgl_s2_reg <= tgl_s1_reg;
    tgl_s3_reg <= tgl_s2_reg;
    comp_s1_reg <= comparator_in;
    comp_s2_reg <= comp_s1_reg;
    tap_s1_reg <= short_cycle_tap_in;
    tap_s2_reg <= tap_s1_reg;
  end

  // Sequencer on the conversion oscillator
  sarcs_pkg::sarcs_state_t state_reg, state_next;
  logic busy_reg, busy_next;
  logic clk_reg, clk_next;
  logic wait_reg, wait_next;
  logic [DATA_W-1:0] data_n_reg, data_n_next;
  logic ser_n_reg, ser_n_next;
  logic [STEP_W-1:0] step_reg, step_next;
  logic [STEP_W-1:0] final_reg, final_next;
  logic start_evt, rise;
  logic [STEP_W-1:0] tap_final;
  logic [IDX_W-1:0] bit_idx;
  logic [IDX_W-1:0] trial_idx;

  assign start_evt = tgl_s2_reg ^ tgl_s3_reg;
  // Open or out-of-range tap means full resolution
  assign tap_final = (tap_s2_reg >= TWO && tap_s2_reg <= FULL) ?
                     STEP_W'(tap_s2_reg - ONE) : FULL;
  assign bit_idx = IDX_W'(FULL - step_reg);
  assign trial_idx = IDX_W'(bit_idx - 1'b1);

  always_comb begin
    state_next = state_reg;
    busy_next = busy_reg;
    clk_next = clk_reg;
    data_n_next = data_n_reg;
    ser_n_next = ser_n_reg;
    step_next = step_reg;
    final_next = final_reg;
    wait_next = wait_reg;
    rise = 1'b0;
    case (state_reg)
      sarcs_pkg::SARCS_IDLE: begin
        // Starts seen outside idle are dropped
        if (start_evt) begin
          busy_next = 1'b1;
          clk_next = 1'b0;
          data_n_next = `SARCS_INIT_WORD;
          step_next = '0;
          final_next = tap_final;
          wait_next = 1'b0;
          state_next = sarcs_pkg::SARCS_RUN;
        end
      end
      sarcs_pkg::SARCS_RUN: begin
        // Low phase stretched to two cycles so the comparator,
        // two stages behind, reflects the latest trial word
        if (clk_reg) begin
          clk_next = 1'b0;
          wait_next = 1'b1;
        end else if (wait_reg) begin
          wait_next = 1'b0;
        end else begin
          clk_next = 1'b1;
          rise = 1'b1;
          if (step_reg == '0) begin
            data_n_next = `SARCS_T0_WORD;
          end else begin
            // Keep shows as low level: negative-true code
            data_n_next[bit_idx] = ~comp_s2_reg;
            ser_n_next = ~comp_s2_reg;
            if (step_reg != final_reg) begin
              data_n_next[trial_idx] = 1'b0;
            end
          end
          step_next = STEP_W'(step_reg + ONE);
          if (step_reg == final_reg) begin
            state_next = sarcs_pkg::SARCS_STOP;
          end
        end
      end
      sarcs_pkg::SARCS_STOP: begin
        // Busy falls one link cycle after last data edge, as the clock falls
        clk_next = 1'b0;
        wait_next = 1'b0;
        busy_next = 1'b0;
        state_next = sarcs_pkg::SARCS_IDLE;
      end
      default: begin
        state_next = sarcs_pkg::SARCS_IDLE;
        busy_next = 1'b0;
        clk_next = 1'b0;
        wait_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_reg) begin
      state_reg <= sarcs_pkg::SARCS_IDLE;
      busy_reg <= 1'b0;
      clk_reg <= 1'b0;
      data_n_reg <= `SARCS_INIT_WORD;
      ser_n_reg <= 1'b1;
      step_reg <= '0;
      final_reg <= FULL;
      wait_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      clk_reg <= clk_next;
      data_n_reg <= data_n_next;
      ser_n_reg <= ser_n_next;
      step_reg <= step_next;
      final_reg <= final_next;
      wait_reg <= wait_next;
    end
  end

  assign busy_out = busy_reg;
  assign conv_clk_out = clk_reg;
  assign parallel_data_n_out = data_n_reg;
  assign serial_data_n_out = ser_n_reg;

  // Checking helpers: rising edges since start
  logic [STEP_W-1:0] rise_cnt_reg;
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_reg || (state_reg == sarcs_pkg::SARCS_IDLE && start_evt)) begin
      rise_cnt_reg <= '0;
    end else if (rise) begin
      rise_cnt_reg <= STEP_W'(rise_cnt_reg + ONE);
    end
  end

  default clocking cb @(posedge link_clk_in);
  endclocking
  default disable iff (!lrst_n_reg);

  busy_set_a: assert property (
    state_reg == sarcs_pkg::SARCS_IDLE && start_evt |=>
      busy_reg && state_reg == sarcs_pkg::SARCS_RUN ##1 clk_reg)
    else $error("busy or clock not started");
  clk_count_a: assert property (
    $fell(busy_reg) |-> rise_cnt_reg == STEP_W'(final_reg + ONE))
    else $error("wrong number of conversion clocks");
  init_word_a: assert property (
    state_reg == sarcs_pkg::SARCS_IDLE && start_evt |=>
      data_n_reg == `SARCS_INIT_WORD ##1 data_n_reg == `SARCS_T0_WORD)
    else $error("initial trial pattern wrong");
  busy_clear_a: assert property (
    state_reg == sarcs_pkg::SARCS_STOP |=> !busy_reg [*2])
    else $error("busy not cleared at end");
  clk_inhibit_a: assert property (
    !busy_reg |-> !clk_reg)
    else $error("clock runs while idle");
  data_edge_a: assert property (
    busy_reg && $past(busy_reg) && $changed(data_n_reg) |-> $rose(clk_reg))
    else $error("data changed off rising edge");
  serial_bit_a: assert property (
    rise && step_reg != '0 |=> ser_n_reg == !$past(comp_s2_reg) &&
      data_n_reg[$past(bit_idx)] == ser_n_reg)
    else $error("serial or parallel bit wrong");
  setup_busy_a: assert property (
    $fell(busy_reg) |-> $stable(data_n_reg) && $past(clk_reg, 1))
    else $error("data not settled before busy fall");
  short_end_a: assert property (
    rise && step_reg == final_reg |=> state_reg == sarcs_pkg::SARCS_STOP
      ##1 !busy_reg)
    else $error("short cycle did not end");
  ignore_start_a: assert property (
    state_reg == sarcs_pkg::SARCS_RUN && start_evt && !rise |=>
      $stable(step_reg) && busy_reg)
    else $error("start during conversion not ignored");
  trial_next_a: assert property (
    rise && step_reg != '0 && step_reg != final_reg |=>
      data_n_reg[$past(trial_idx)] == 1'b0)
    else $error("next bit not put on trial");
  ser_edge_a: assert property (
    $changed(ser_n_reg) |-> $rose(clk_reg))
    else $error("serial bit changed off rising edge");
  rise_busy_a: assert property (
    $rose(clk_reg) |-> busy_reg)
    else $error("clock rose outside conversion");
  low_phase_a: assert property (
    $rose(clk_reg) |=> !clk_reg ##1 !clk_reg)
    else $error("clock low phase too short");
  idle_low_a: assert property (
    state_reg == sarcs_pkg::SARCS_IDLE |-> !clk_reg && !busy_reg)
    else $error("clock or busy high in idle");
  busy_source_a: assert property (
    $rose(busy_reg) |-> $past(state_reg == sarcs_pkg::SARCS_IDLE &&
      start_evt))
    else $error("busy rose without accepted start");
  step_bound_a: assert property (
    state_reg == sarcs_pkg::SARCS_RUN |-> step_reg <= final_reg)
    else $error("step ran past final bit");
  start_clear_a: assert property (
    $rose(busy_reg) |-> data_n_reg == `SARCS_INIT_WORD && !clk_reg)
    else $error("start did not initialise");
  idle_hold_a: assert property (
    state_reg == sarcs_pkg::SARCS_IDLE && !start_evt |=> $stable(data_n_reg))
    else $error("result changed while idle");

  full_conv_c: cover property ($fell(busy_reg) && final_reg == FULL);
  short_conv_c: cover property ($fell(busy_reg) && final_reg == STEP_W'(10));
  busy_start_c: cover property (busy_reg && start_evt);
  keep_bit_c: cover property (rise && comp_s2_reg && step_reg == FULL);
  short_8_c: cover property ($fell(busy_reg) && final_reg == STEP_W'(8));
endmodule // sarcs_top
`default_nettype wire

// File: verification/sarcs_host_model.sv
// Host model: comparator source, receiving shift register, busy latch
`timescale 1ns/1ps
`default_nettype none
module sarcs_host_model (
  input wire logic [15:0] target_in,
  input wire logic busy_in,
  input wire logic conv_clk_in,
  input wire logic [15:0] parallel_n_in,
  input wire logic serial_n_in,
  output logic comparator_out,
  output logic [15:0] shift_reg_out,
  output logic [15:0] latched_n_out,
  output int falls_out
);
  // Keep the trial bit while the trial word does not pass the input
  assign comparator_out = (~parallel_n_in <= target_in);
  initial falls_out = 0;
  always @(posedge busy_in) begin
    falls_out = 0;
  end
  // Capture one link cycle (160 ns) after the data edge, well past settling
  always @(negedge conv_clk_in) begin
    shift_reg_out = {shift_reg_out[14:0], serial_n_in};
    falls_out = falls_out + 1;
  end
  always @(negedge busy_in) begin
    latched_n_out = parallel_n_in;
  end
endmodule // sarcs_host_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [4:0] tap = 5'h00;
  logic [15:0] target = 16'h0000;
  logic busy, conv_clk, serial_n, comp;
  logic [15:0] par_n, shreg, latched;
  int falls;
  int failures = 0;
  int n_checks = 0;
  logic [4:0] taps[8] = '{5'h00, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0b, 5'h09,
    5'h11};
  int fs[8] = '{16, 15, 14, 13, 12, 10, 8, 16};
  logic [15:0] tgts[8] = '{16'h8000, 16'hffff, 16'h0000, 16'ha5c3,
    16'h7fff, 16'h3c96, 16'h0001, 16'h5a5a};
  always #12.5 sys_clk = ~sys_clk;
  // Link edges never meet rising system edges; phases otherwise unrelated
  always #80 link_clk = ~link_clk;
  sarcs_top i_sarcs_top (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .link_clk_in(link_clk), .convert_start_in(start),
    .comparator_in(comp), .short_cycle_tap_in(tap), .busy_out(busy),
    .conv_clk_out(conv_clk), .parallel_data_n_out(par_n),
    .serial_data_n_out(serial_n));
  sarcs_host_model i_sarcs_host_model (.target_in(target),
    .busy_in(busy), .conv_clk_in(conv_clk), .parallel_n_in(par_n),
    .serial_n_in(serial_n), .comparator_out(comp),
    .shift_reg_out(shreg), .latched_n_out(latched), .falls_out(falls));
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wait_busy(input logic lvl, input int bound);
    for (int i = 0; i < bound && busy !== lvl; i++) @(posedge sys_clk);
    if (busy !== lvl) begin
      failures++;
      $display("MISMATCH %0t busy wait timed out", $time);
      tally_and_finish();
    end
  endtask
  task automatic pulse_start();
    @(posedge sys_clk);
    start <= 1'b1;
    repeat (4) @(posedge sys_clk);
    start <= 1'b0;
  endtask
  task automatic convert(input logic [15:0] tgt, input logic [4:0] tp,
    input int f);
    logic [15:0] mask;
    int bad;
    mask = 16'hffff << (16 - f);
    bad = 0;
    @(posedge sys_clk);
    target <= tgt;
    tap <= tp;
    pulse_start();
    wait_busy(1'b1, 100);
    wait_busy(1'b0, 600);
    @(posedge sys_clk);
    check(latched === ~(tgt & mask), "parallel word");
    check(falls == f + 1, "clock cycle count");
    check(((shreg ^ ~(tgt >> (16 - f))) & ~(16'hffff << f)) === 16'h0000,
      "serial word");
    check(par_n === ~(tgt & mask), "parallel held after end");
    // Idle gap also covers the spacing needed before the next start
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (busy !== 1'b0 || conv_clk !== 1'b0) bad++;
    end
    check(bad == 0, "clock or busy active when idle");
  endtask
  task automatic ignore_busy_start();
    fork
      convert(16'h1234, 5'h00, 16);
      begin
        wait_busy(1'b1, 100);
        pulse_start();
      end
    join
  endtask
  task automatic reset_idle();
    check(busy === 1'b0 && conv_clk === 1'b0 && par_n === 16'hffff &&
      serial_n === 1'b1, "idle outputs after reset");
  endtask
  initial begin
    // Short pin reset; the block stretches it for the link side
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (80) @(posedge sys_clk);
    reset_idle();
    for (int i = 0; i < 8; i++) begin
      convert(tgts[i], taps[i], fs[i]);
    end
    ignore_busy_start();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
